// ### rtl/slc_defines.vh
// Constants for the sleep controller
`ifndef SLC_DEFINES_VH
`define SLC_DEFINES_VH

`define SLC_ADDR_W 4
`define SLC_CTRL_OFS 4'h0
`define SLC_STAT_OFS 4'h1
`define SLC_RSTBY_OFS 4'h2
`define SLC_WAKECFG_OFS 4'h3

`define SLC_EN_BIT 0
`define SLC_MODE_LSB 1
`define SLC_MODE_MSB 2
`define SLC_CTRL_MASK 8'h07
`define SLC_CTRL_RST 8'h00

`define SLC_MODE_IDLE 2'h0
`define SLC_MODE_STBY 2'h1
`define SLC_MODE_PDWN 2'h2

`define SLC_RSTBY_RTC 0
`define SLC_RSTBY_CCL 1
`define SLC_RSTBY_ADC 2
`define SLC_RSTBY_TCA 3
`define SLC_RSTBY_TCB 4
`define SLC_RSTBY_AC 5
`define SLC_RSTBY_MAIN 6
`define SLC_RSTBY_MASK 8'h7f

`define SLC_CFG_BODRDY 0
`define SLC_CFG_PINASYNC 1
`define SLC_WAKECFG_MASK 8'h03

`define SLC_FILT_ASYNC 2'h0
`define SLC_EDGE_ASYNC 1'h0

`define SLC_WAKE_CYC 3'h6
`define SLC_CNT_W 3
`define SLC_CNT_ONE 3'h1
`define SLC_CNT_ZERO 3'h0

`define SLC_BOD_MODE_WAIT 2'h3

`endif

// ### rtl/slc_wake_timer.v
// Wake-up delay counter for the sleep controller
`timescale 1ns/100ps
`default_nettype none

module slc_wake_timer (
    input wire clk_i,
    input wire rst_n_i,
    input wire start_i,
    input wire osc_wait_i,
    input wire osc_ready_i,
    input wire bod_wait_i,
    input wire bod_ready_i,
    output wire done_o
);

`include "slc_defines.vh"

reg [`SLC_CNT_W-1:0] cnt_q;
reg [`SLC_CNT_W-1:0] cnt_d;
reg osc_wait_q;
reg osc_wait_d;
reg bod_wait_q;
reg bod_wait_d;
reg busy_q;
reg busy_d;

//////////////////////////////////////////////////////////////////////////////
// Oscillator start-up first, then six cycles, then optional brown-out gate
always @* begin
    cnt_d = cnt_q;
    osc_wait_d = osc_wait_q;
    bod_wait_d = bod_wait_q;
    busy_d = busy_q;
    if (start_i) begin
        busy_d = 1'b1;
        osc_wait_d = osc_wait_i;
        bod_wait_d = bod_wait_i;
        cnt_d = `SLC_WAKE_CYC;
    end else if (busy_q) begin
        if (osc_wait_q) begin
            if (osc_ready_i) begin
                osc_wait_d = 1'b0;
            end
        end else if (cnt_q != `SLC_CNT_ZERO) begin
            cnt_d = cnt_q - `SLC_CNT_ONE;
        end else if (!bod_wait_q || bod_ready_i) begin
            busy_d = 1'b0;
        end
    end
end

always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        cnt_q <= `SLC_CNT_ZERO;
        osc_wait_q <= 1'b0;
        bod_wait_q <= 1'b0;
        busy_q <= 1'b0;
    end else begin
        cnt_q <= cnt_d;
        osc_wait_q <= osc_wait_d;
        bod_wait_q <= bod_wait_d;
        busy_q <= busy_d;
    end
end

assign done_o = busy_q && !osc_wait_q && (cnt_q == `SLC_CNT_ZERO) &&
    (!bod_wait_q || bod_ready_i);

endmodule // slc_wake_timer

`default_nettype wire

// ### rtl/slc_sleep_ctrl.v
// Sleep controller: mode sequencing, clock gating and wake qualification
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module slc_sleep_ctrl (
    input wire clk_i,
    input wire rst_n_i,
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire sleep_instr_i,
    input wire [1:0] bod_active_mode_i,
    input wire bod_ready_i,
    input wire osc_ready_i,
    input wire debug_break_i,
    input wire irq_pin_i,
    input wire irq_two_wire_iface_i,
    input wire irq_voltage_level_monitor_i,
    input wire irq_configurable_logic_i,
    input wire [1:0] lut_filter_select_i,
    input wire lut_edge_detect_i,
    input wire irq_rtc_i,
    input wire irq_periodic_interrupt_timer_i,
    input wire irq_usart_i,
    input wire irq_usart_sof_i,
    input wire irq_timer_type_a_i,
    input wire irq_timer_type_b_i,
    input wire irq_analog_converter_i,
    input wire irq_analog_comparator_i,
    input wire irq_other_i,
    output wire cpu_clk_en_o,
    output wire cpu_resume_o,
    output wire main_osc_en_o,
    output wire periph_clk_en_o,
    output wire rtc_clk_en_o,
    output wire pit_en_o,
    output wire watchdog_clk_en_o,
    output wire brownout_clk_en_o,
    output wire configurable_logic_en_o,
    output wire analog_converter_en_o,
    output wire timer_type_a_en_o,
    output wire timer_type_b_en_o,
    output wire analog_comparator_en_o,
    output wire osc32k_en_o,
    output wire [3:0] mode_o
);

`include "slc_defines.vh"

localparam [3:0] ST_ACTIVE = 4'h1;
localparam [3:0] ST_IDLE = 4'h2;
localparam [3:0] ST_STBY = 4'h4;
localparam [3:0] ST_PDWN = 4'h8;

//////////////////////////////////////////////////////////////////////////////
// Registers
reg [7:0] ctrl_q;
reg [7:0] rstby_q;
reg [7:0] wakecfg_q;
reg [3:0] state_q;
reg [3:0] state_d;
reg waking_q;
reg waking_d;
reg wake_start;
reg resume_q;

wire [1:0] sleep_mode_select = ctrl_q[`SLC_MODE_MSB:`SLC_MODE_LSB];
wire sleep_enable_bit = ctrl_q[`SLC_EN_BIT];
wire sel = (addr_i == `SLC_CTRL_OFS) || (addr_i == `SLC_RSTBY_OFS) ||
    (addr_i == `SLC_WAKECFG_OFS);

function rsb;
    input [7:0] v;
    input integer b;
    begin
        rsb = v[b];
    end
endfunction

// Registers are never cleared by sleep transitions, only by reset
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        ctrl_q <= `SLC_CTRL_RST;
        rstby_q <= `SLC_CTRL_RST;
        wakecfg_q <= `SLC_CTRL_RST;
    end else if (wr_i) begin
        case (addr_i)
            `SLC_CTRL_OFS: begin
                ctrl_q <= wdata_i & `SLC_CTRL_MASK;
            end
            `SLC_RSTBY_OFS: begin
                rstby_q <= wdata_i & `SLC_RSTBY_MASK;
            end
            `SLC_WAKECFG_OFS: begin
                wakecfg_q <= wdata_i & `SLC_WAKECFG_MASK;
            end
            default: begin
            end
        endcase
    end
end

always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        rdata_o <= 8'h00;
    end else if (rd_i && sel) begin
        case (addr_i)
            `SLC_CTRL_OFS: rdata_o <= ctrl_q;
            `SLC_RSTBY_OFS: rdata_o <= rstby_q;
            `SLC_WAKECFG_OFS: rdata_o <= wakecfg_q;
            default: rdata_o <= 8'h00;
        endcase
    end else if (rd_i && addr_i == `SLC_STAT_OFS) begin
        rdata_o <= {3'h0, waking_q, state_q};
    end else begin
        rdata_o <= 8'h00;
    end
end

//////////////////////////////////////////////////////////////////////////////
// Wake source qualification
wire lut_async = (lut_filter_select_i == `SLC_FILT_ASYNC) &&
    (lut_edge_detect_i == `SLC_EDGE_ASYNC);
wire pin_async = wakecfg_q[`SLC_CFG_PINASYNC];

wire wake_common = irq_two_wire_iface_i | irq_voltage_level_monitor_i;

wire wake_idle = wake_common | irq_pin_i | irq_configurable_logic_i | irq_rtc_i | irq_usart_sof_i |
    irq_periodic_interrupt_timer_i | irq_usart_i | irq_timer_type_a_i |
    irq_timer_type_b_i | irq_analog_converter_i | irq_analog_comparator_i |
    irq_other_i;

wire wake_stby = wake_common | irq_pin_i |
    (irq_configurable_logic_i & lut_async & rsb(rstby_q, `SLC_RSTBY_CCL)) |
    (irq_rtc_i & rsb(rstby_q, `SLC_RSTBY_RTC)) | irq_periodic_interrupt_timer_i |
    irq_usart_sof_i |
    (irq_timer_type_a_i & rsb(rstby_q, `SLC_RSTBY_TCA)) |
    (irq_timer_type_b_i & rsb(rstby_q, `SLC_RSTBY_TCB)) |
    (irq_analog_converter_i & rsb(rstby_q, `SLC_RSTBY_ADC)) |
    (irq_analog_comparator_i & rsb(rstby_q, `SLC_RSTBY_AC));

wire wake_pdwn = wake_common | (irq_pin_i & pin_async) |
    (irq_configurable_logic_i & lut_async) | irq_periodic_interrupt_timer_i;

reg wake_req;
always @* begin
    case (state_q)
        ST_IDLE: wake_req = wake_idle;
        ST_STBY: wake_req = wake_stby;
        ST_PDWN: wake_req = wake_pdwn;
        default: wake_req = 1'b0;
    endcase
end

//////////////////////////////////////////////////////////////////////////////
// Mode state machine
wire timer_done;
wire mode_ok = (sleep_mode_select == `SLC_MODE_IDLE) || (sleep_mode_select == `SLC_MODE_STBY) ||
    (sleep_mode_select == `SLC_MODE_PDWN);
wire stby_main = rsb(rstby_q, `SLC_RSTBY_MAIN);
wire osc_needed = (state_q == ST_PDWN) || ((state_q == ST_STBY) && !stby_main);

always @* begin
    state_d = state_q;
    waking_d = waking_q;
    wake_start = 1'b0;
    case (state_q)
        ST_ACTIVE: begin
            if (sleep_instr_i && sleep_enable_bit && mode_ok) begin
                case (sleep_mode_select)
                    `SLC_MODE_IDLE: state_d = ST_IDLE;
                    `SLC_MODE_STBY: state_d = ST_STBY;
                    default: state_d = ST_PDWN;
                endcase
            end
        end
        ST_IDLE, ST_STBY, ST_PDWN: begin
            if (!waking_q && (wake_req || debug_break_i)) begin
                waking_d = 1'b1;
                wake_start = 1'b1;
            end else if (waking_q && timer_done) begin
                waking_d = 1'b0;
                state_d = ST_ACTIVE;
            end
        end
        default: begin
            state_d = ST_ACTIVE;
            waking_d = 1'b0;
        end
    endcase
end

// Asynchronous reset returns straight to Active from any sleep mode
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        state_q <= ST_ACTIVE;
        waking_q <= 1'b0;
        resume_q <= 1'b0;
    end else begin
        state_q <= state_d;
        waking_q <= waking_d;
        resume_q <= waking_q && timer_done;
    end
end

slc_wake_timer u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(wake_start),
    .osc_wait_i(osc_needed),
    .osc_ready_i(osc_ready_i),
    .bod_wait_i(bod_active_mode_i == `SLC_BOD_MODE_WAIT),
    .bod_ready_i(bod_ready_i),
    .done_o(timer_done)
);

//////////////////////////////////////////////////////////////////////////////
// Clock and peripheral gating
wire act = (state_q == ST_ACTIVE);
wire idl = (state_q == ST_IDLE);
wire stb = (state_q == ST_STBY);
wire wk = waking_q && !osc_needed;

assign cpu_clk_en_o = act;
assign cpu_resume_o = resume_q;
assign main_osc_en_o = act || idl || (stb && stby_main) || (waking_q && osc_needed);
assign periph_clk_en_o = act || idl || wk;
assign rtc_clk_en_o = act || idl || (stb && rsb(rstby_q, `SLC_RSTBY_RTC));
assign pit_en_o = 1'b1;
assign watchdog_clk_en_o = 1'b1;
assign brownout_clk_en_o = 1'b1;
assign osc32k_en_o = 1'b1;
assign configurable_logic_en_o = act || idl || (stb && rsb(rstby_q, `SLC_RSTBY_CCL));
assign analog_converter_en_o = act || idl || (stb && rsb(rstby_q, `SLC_RSTBY_ADC));
assign timer_type_a_en_o = act || idl || (stb && rsb(rstby_q, `SLC_RSTBY_TCA));
assign timer_type_b_en_o = act || idl || (stb && rsb(rstby_q, `SLC_RSTBY_TCB));
assign analog_comparator_en_o = act || idl || (stb && rsb(rstby_q, `SLC_RSTBY_AC));
assign mode_o = state_q;

endmodule // slc_sleep_ctrl

`default_nettype wire

// ### tb/slc_checker_properties.sv
// Checker for the sleep controller ports
`timescale 1ns/100ps
`default_nettype none
module slc_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic sleep_instr_i,
    input wire logic irq_other_i,
    input wire logic cpu_clk_en_o,
    input wire logic cpu_resume_o,
    input wire logic main_osc_en_o,
    input wire logic periph_clk_en_o,
    input wire logic pit_en_o,
    input wire logic watchdog_clk_en_o,
    input wire logic osc32k_en_o,
    input wire logic analog_converter_en_o,
    input wire logic [3:0] mode_o
);
    logic [2:0] ctrl_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            ctrl_q <= 3'h0;
        else if (wr_i && addr_i == 4'h0)
            ctrl_q <= wdata_i[2:0];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    a_cpu_clk_gate: assert property (cpu_clk_en_o == (mode_o == 4'h1))
        else $error("cpu clock enable wrong");
    a_sleep_entry: assert property (mode_o == 4'h1 && sleep_instr_i && ctrl_q[0]
        && ctrl_q[2:1] != 2'h3 |=> mode_o == (4'h2 << ctrl_q[2:1]))
        else $error("sleep mode not entered");
    a_sleep_nop: assert property (mode_o == 4'h1 && sleep_instr_i
        && (!ctrl_q[0] || ctrl_q[2:1] == 2'h3) |=> mode_o == 4'h1)
        else $error("sleep taken while disabled");
    a_from_active: assert property (mode_o != 4'h1 |=> mode_o == 4'h1 || $stable(mode_o))
        else $error("sleep mode changed while asleep");
    a_idle_wake: assert property (mode_o == 4'h2 && $rose(irq_other_i)
        |-> (mode_o == 4'h2) [*6] ##[1:3] mode_o == 4'h1)
        else $error("idle wake timing wrong");
    a_resume_after: assert property ($rose(mode_o == 4'h1) |-> cpu_resume_o)
        else $error("no resume after wake");
    a_resume_once: assert property (cpu_resume_o |-> mode_o == 4'h1 ##1 !cpu_resume_o)
        else $error("resume pulse wrong");
    a_pdown_off: assert property (mode_o == 4'h8
        |-> !periph_clk_en_o && !analog_converter_en_o)
        else $error("clock left on in power down");
    a_pdown_osc: assert property ($rose(mode_o == 4'h8) |-> !main_osc_en_o)
        else $error("main oscillator on entering power down");
    a_idle_run: assert property (mode_o == 4'h2
        |-> main_osc_en_o && periph_clk_en_o && analog_converter_en_o)
        else $error("clock stopped in idle");
    a_always_on: assert property (pit_en_o && watchdog_clk_en_o && osc32k_en_o)
        else $error("always-on clock stopped");
    c_idle: cover property (mode_o == 4'h2);
    c_stby: cover property (mode_o == 4'h4);
    c_pdown: cover property (mode_o == 4'h8);
    c_resume: cover property (cpu_resume_o);
endmodule // slc_checker
bind slc_sleep_ctrl slc_checker chk_i (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
    .sleep_instr_i, .irq_other_i, .cpu_clk_en_o, .cpu_resume_o, .main_osc_en_o,
    .periph_clk_en_o, .pit_en_o, .watchdog_clk_en_o, .osc32k_en_o,
    .analog_converter_en_o, .mode_o);
`default_nettype wire

// ### tb/slc_cpu_model.sv
// CPU model issuing register accesses and sleep
`timescale 1ns/100ps
`default_nettype none
module slc_cpu_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [3:0] addr_o = 4'h0,
    output logic [7:0] wdata_o = 8'h00,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output logic slp_o = 1'b0
);
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        q = rdata_i;
    endtask
    // Mode and enable written, then sleep
    task automatic slp(input logic [2:0] c);
        wr(4'h0, {5'h00, c});
        @(posedge clk_i);
        slp_o <= 1'b1;
        @(posedge clk_i);
        slp_o <= 1'b0;
        #1;
    endtask
endmodule // slc_cpu_model
`default_nettype wire

// ### tb/slc_sleep_ctrl_bench.sv
// Testbench for the sleep controller
`timescale 1ns/100ps
`default_nettype none
module slc_sleep_ctrl_bench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr_i, mode_o;
    logic [7:0] wdata_i, rdata_o, q;
    logic wr_i, rd_i, sleep_instr_i;
    logic [1:0] bod_active_mode_i, lut_filter_select_i;
    logic bod_ready_i, osc_ready_i, debug_break_i, lut_edge_detect_i;
    logic [12:0] irq = 13'h0;
    logic cpu_clk_en_o, cpu_resume_o, main_osc_en_o, periph_clk_en_o, rtc_clk_en_o, pit_en_o;
    logic watchdog_clk_en_o, brownout_clk_en_o, configurable_logic_en_o, analog_converter_en_o;
    logic timer_type_a_en_o, timer_type_b_en_o, analog_comparator_en_o, osc32k_en_o;
    int err_total = 0, checks_done = 0;
    always #5 clk_i = ~clk_i;
    slc_cpu_model cpu (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
        .wr_o(wr_i), .rd_o(rd_i), .slp_o(sleep_instr_i));
    slc_sleep_ctrl uut (.*, .irq_pin_i(irq[0]), .irq_two_wire_iface_i(irq[1]),
        .irq_voltage_level_monitor_i(irq[2]), .irq_configurable_logic_i(irq[3]),
        .irq_rtc_i(irq[4]), .irq_periodic_interrupt_timer_i(irq[5]), .irq_usart_i(irq[6]),
        .irq_usart_sof_i(irq[7]), .irq_timer_type_a_i(irq[8]), .irq_timer_type_b_i(irq[9]),
        .irq_analog_converter_i(irq[10]), .irq_analog_comparator_i(irq[11]),
        .irq_other_i(irq[12]));
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wact(input int n, output int c);
        c = 0;
        while (mode_o !== 4'h1) begin
            tick(1);
            c++;
            if (c > n) begin
                chk(8'h00, 8'h01);
                report_and_stop;
            end
        end
    endtask
    task automatic try(input logic [2:0] c, input int s, input logic e);
        int n;
        cpu.slp(c);
        chk(mode_o, 8'h02 << c[2:1]);
        @(posedge clk_i);
        irq[s] <= 1'b1;
        tick(20);
        chk(mode_o == 4'h1, e);
        @(posedge clk_i);
        debug_break_i <= 1'b1;
        wact(40, n);
        @(posedge clk_i);
        irq[s] <= 1'b0;
        debug_break_i <= 1'b0;
        tick(2);
    endtask
    task automatic t_regs;
        cpu.rd(4'h0, q);
        chk(q, 8'h00);
        cpu.wr(4'h0, 8'hff);
        cpu.rd(4'h0, q);
        chk(q, 8'h07);
        cpu.rd(4'h1, q);
        chk(q, 8'h01);
        cpu.rd(4'hf, q);
        chk(q, 8'h00);
        cpu.slp(3'h7);
        chk(mode_o, 8'h01);
        cpu.slp(3'h4);
        chk(mode_o, 8'h01);
    endtask
    task automatic t_idle;
        int n;
        cpu.slp(3'h1);
        chk({cpu_clk_en_o, periph_clk_en_o, mode_o}, 8'h12);
        tick(20);
        chk(mode_o, 8'h02);
        @(posedge clk_i);
        irq[12] <= 1'b1;
        wact(20, n);
        chk(n, 8'h08);
        chk(cpu_resume_o, 8'h01);
        tick(1);
        chk(cpu_resume_o, 8'h00);
        irq[12] <= 1'b0;
    endtask
    task automatic t_osc;
        int n;
        cpu.wr(4'h2, 8'h08);
        osc_ready_i <= 1'b0;
        cpu.slp(3'h3);
        chk({timer_type_a_en_o, analog_converter_en_o, periph_clk_en_o, main_osc_en_o}, 8'h08);
        @(posedge clk_i);
        irq[0] <= 1'b1;
        tick(30);
        chk(mode_o, 8'h04);
        @(posedge clk_i);
        osc_ready_i <= 1'b1;
        wact(20, n);
        @(posedge clk_i);
        irq[0] <= 1'b0;
        cpu.wr(4'h2, 8'h00);
    endtask
    task automatic t_bod;
        int n;
        @(posedge clk_i);
        bod_active_mode_i <= 2'h3;
        bod_ready_i <= 1'b0;
        cpu.slp(3'h1);
        @(posedge clk_i);
        irq[0] <= 1'b1;
        tick(30);
        chk(mode_o, 8'h02);
        @(posedge clk_i);
        bod_ready_i <= 1'b1;
        wact(5, n);
        @(posedge clk_i);
        irq[0] <= 1'b0;
        bod_active_mode_i <= 2'h0;
    endtask
    task automatic t_table;
        logic [12:0] tb [4] = '{13'h1fff, 13'h00a7, 13'h0fbf, 13'h002e};
        logic [2:0] cf [4] = '{3'h1, 3'h3, 3'h3, 3'h5};
        for (int m = 0; m < 4; m++) begin
            cpu.wr(4'h2, m == 2 ? 8'h7f : 8'h00);
            for (int s = 0; s < 13; s++)
                try(cf[m], s, tb[m][s]);
        end
        cpu.wr(4'h2, 8'h00);
    endtask
    task automatic t_pdown;
        cpu.wr(4'h3, 8'h02);
        try(3'h5, 0, 1'b1);
        cpu.wr(4'h3, 8'h00);
        lut_filter_select_i <= 2'h1;
        try(3'h5, 3, 1'b0);
        lut_filter_select_i <= 2'h0;
        lut_edge_detect_i <= 1'b1;
        try(3'h5, 3, 1'b0);
        lut_edge_detect_i <= 1'b0;
    endtask
    task automatic t_reset;
        cpu.slp(3'h5);
        chk(mode_o, 8'h08);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        #1;
        chk(mode_o, 8'h01);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        cpu.rd(4'h0, q);
        chk(q, 8'h00);
    endtask
    initial begin
        bod_active_mode_i <= 2'h0;
        lut_filter_select_i <= 2'h0;
        bod_ready_i <= 1'b1;
        osc_ready_i <= 1'b1;
        debug_break_i <= 1'b0;
        lut_edge_detect_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs;
        t_idle;
        t_osc;
        t_bod;
        t_table;
        t_pdown;
        t_reset;
        report_and_stop;
    end
endmodule // slc_sleep_ctrl_bench
`default_nettype wire
